// [design/cct_defines.svh]
`ifndef CCT_DEFINES_SVH
`define CCT_DEFINES_SVH

`define CCT_NCH          8
`define CCT_BT_W         16
`define CCT_PSC_W        8
`define CCT_FILT_SAMPLES 3
`define CCT_RST_DELAY    2
`define CCT_GATE_CH      6
`define CCT_DEB_CH       7
`define CCT_PRE_W        5
`define CCT_BCK_MASK0    5'h00
`define CCT_BCK_MASK1    5'h01
`define CCT_BCK_MASK2    5'h07
`define CCT_BCK_MASK3    5'h1F
`define CCT_DIV8_MASK    5'h07

`endif

// [design/cct_filter.sv]
`timescale 1ns/1ps
`default_nettype none
module cct_filter #(
  parameter int unsigned CW = 9
) (
  // clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          rst_n_i,
  // control
  input  wire logic          enable_i,
  input  wire logic          sample_en_i,
  input  wire logic [CW-1:0] need_i,
  // level
  input  wire logic          level_i,
  output logic               level_o
);

  logic [CW-1:0] run_cnt;

  // =========================================================
  // consecutive sample counter
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= 1'b0;
      run_cnt <= '0;
    end else if (!enable_i) begin
      level_o <= level_i;
      run_cnt <= '0;
    end else if (sample_en_i) begin
      if (level_i == level_o) begin
        run_cnt <= '0;
      end else if (run_cnt + 1'b1 >= need_i) begin
        level_o <= level_i;
        run_cnt <= '0;
      end else begin
        run_cnt <= run_cnt + 1'b1;
      end
    end
  end

  // =========================================================
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_filter_hold: assert property (
    enable_i && $past(enable_i) && (level_o != $past(level_o)) |->
      $past(sample_en_i) && ($past(run_cnt) + 1'b1 >= $past(need_i)))
    else $error("filtered level changed without enough equal samples");

endmodule : cct_filter
`default_nettype wire

// [design/cct_pkg.sv]
package cct_pkg;

  typedef enum logic [1:0] {
    CCT_EDGE_NONE = 2'b00,
    CCT_EDGE_RISE = 2'b01,
    CCT_EDGE_FALL = 2'b10,
    CCT_EDGE_BOTH = 2'b11
  } cct_edge_t;

  typedef enum logic [1:0] {
    CCT_FILT_OFF   = 2'b00,
    CCT_FILT_RSV   = 2'b01,
    CCT_FILT_UNDIV = 2'b10,
    CCT_FILT_BASE  = 2'b11
  } cct_filt_t;

endpackage : cct_pkg

// [design/cct_top.sv]
`include "cct_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module cct_top #(
  parameter int unsigned BW  = `CCT_BT_W,
  parameter int unsigned PSW = `CCT_PSC_W
) (
  // clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_n_i,
  // base timer control
  input  wire logic                    base_timer_run_i,
  input  wire logic [1:0]              base_clock_select_i,
  input  wire logic                    reset_on_match0_i,
  input  wire logic                    input_select_i,
  input  wire logic [PSW-1:0]          debounce_setting_i,
  // capture channels
  input  wire logic [`CCT_NCH-1:0]     trigger_input_pin_i,
  input  wire logic [2*`CCT_NCH-1:0]   edge_select_i,
  input  wire logic [2*`CCT_NCH-1:0]   filter_select_i,
  input  wire logic [1:0]              trigger_gate_enable_i,
  input  wire logic [1:0]              gate_clear_i,
  input  wire logic [1:0]              trigger_prescale_enable_i,
  input  wire logic [2*PSW-1:0]        prescale_setting_i,
  input  wire logic [`CCT_NCH-1:0]     capture_ack_i,
  output logic      [`CCT_NCH*BW-1:0]  capture_value_o,
  output logic      [`CCT_NCH-1:0]     capture_irq_o,
  // compare channels
  input  wire logic [`CCT_NCH*BW-1:0]  compare_value_i,
  input  wire logic [`CCT_NCH-1:0]     compare_ack_i,
  output logic      [`CCT_NCH-1:0]     match_o,
  output logic      [`CCT_NCH-1:0]     compare_irq_o,
  output logic      [`CCT_NCH-1:0]     compare_out_o,
  // base timer
  output logic      [BW-1:0]           base_count_o
);

  localparam int unsigned NCH = `CCT_NCH;
  localparam int unsigned RPW = `CCT_RST_DELAY - 1;

  logic [`CCT_PRE_W-1:0] pre_cnt;
  logic [`CCT_PRE_W-1:0] bck_mask;
  logic                  bt_tick;
  logic                  div8_tick;
  logic [RPW-1:0]        rst_pend;
  logic [NCH-1:0]        raw_match;
  wire  logic [NCH-1:0]  take_v;
  wire  logic [NCH-1:0]  hit_v;
  wire  logic [NCH-1:0]  flt_v;
  wire  logic [NCH-1:0]  lvl_v;
  wire  logic [1:0]      gate_v;

  // =========================================================
  // clock dividers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  always_comb begin
    case (base_clock_select_i)
      2'h0:    bck_mask = `CCT_BCK_MASK0;
      2'h1:    bck_mask = `CCT_BCK_MASK1;
      2'h2:    bck_mask = `CCT_BCK_MASK2;
      default: bck_mask = `CCT_BCK_MASK3;
    endcase
    bt_tick   = base_timer_run_i && ((pre_cnt & bck_mask) == bck_mask);
    div8_tick = (pre_cnt & `CCT_DIV8_MASK) == `CCT_DIV8_MASK;
  end

  // =========================================================
  // base timer
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_count_o <= '0;
      rst_pend     <= '0;
    end else if (bt_tick) begin
      rst_pend <= RPW'({rst_pend, raw_match[0] & reset_on_match0_i});
      if (rst_pend[RPW-1]) begin
        base_count_o <= '0;
      end else begin
        base_count_o <= base_count_o + 1'b1;
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      raw_match[c] = bt_tick && (base_count_o == compare_value_i[c*BW +: BW]);
    end
  end

  // =========================================================
  // capture trigger paths
  for (genvar i = 0; i < NCH; i++) begin : g_cap
    cct_pkg::cct_edge_t esel;
    cct_pkg::cct_filt_t fsel;
    logic               deb_lvl;
    logic               filt_lvl;
    logic               lvl_q;
    logic               filt_smp;

    always_comb begin
      esel = cct_pkg::cct_edge_t'(edge_select_i[2*i +: 2]);
      fsel = cct_pkg::cct_filt_t'(filter_select_i[2*i +: 2]);
      case (fsel)
        cct_pkg::CCT_FILT_UNDIV: filt_smp = 1'b1;
        cct_pkg::CCT_FILT_BASE:  filt_smp = bt_tick;
        default:                 filt_smp = 1'b0;
      endcase
    end

    if (i == `CCT_DEB_CH) begin : g_deb
      cct_filter #(.CW(PSW+1)) u_deb (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .enable_i    (input_select_i),
        .sample_en_i (div8_tick),
        .need_i      ({1'b0, debounce_setting_i} + 1'b1),
        .level_i     (trigger_input_pin_i[i]),
        .level_o     (deb_lvl)
      );
    end else begin : g_nodeb
      assign deb_lvl = trigger_input_pin_i[i];
    end

    cct_filter #(.CW(PSW+1)) u_flt (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .enable_i    (fsel == cct_pkg::CCT_FILT_UNDIV || fsel == cct_pkg::CCT_FILT_BASE),
      .sample_en_i (filt_smp),
      .need_i      ((PSW+1)'(`CCT_FILT_SAMPLES)),
      .level_i     (deb_lvl),
      .level_o     (filt_lvl)
    );

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        lvl_q <= 1'b0;
      end else begin
        lvl_q <= filt_lvl;
      end
    end

    assign flt_v[i] = filt_lvl;
    assign lvl_v[i] = lvl_q;
    assign hit_v[i] = ((esel == cct_pkg::CCT_EDGE_RISE || esel == cct_pkg::CCT_EDGE_BOTH)
                       && filt_lvl && !lvl_q)
                    || ((esel == cct_pkg::CCT_EDGE_FALL || esel == cct_pkg::CCT_EDGE_BOTH)
                       && !filt_lvl && lvl_q);

    if (i >= `CCT_GATE_CH) begin : g_gp
      localparam int unsigned K = i - `CCT_GATE_CH;
      logic           gate_shut;
      logic           first;
      logic           pre_ok;
      logic [PSW-1:0] pcnt;

      always_comb begin
        pre_ok = !trigger_prescale_enable_i[K] || first
              || (pcnt >= prescale_setting_i[K*PSW +: PSW]);
      end

      assign take_v[i] = hit_v[i] && !gate_shut && pre_ok;
      assign gate_v[K] = gate_shut;

      // the shutting capture wins over a clear in the same cycle
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          gate_shut <= 1'b0;
        end else if (take_v[i] && trigger_gate_enable_i[K]) begin
          gate_shut <= 1'b1;
        end else if (gate_clear_i[K] || raw_match[i] || !trigger_gate_enable_i[K]) begin
          gate_shut <= 1'b0;
        end
      end

      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          first <= 1'b1;
          pcnt  <= '0;
        end else if (!trigger_prescale_enable_i[K]) begin
          first <= 1'b1;
          pcnt  <= '0;
        end else if (hit_v[i] && !gate_shut) begin
          if (pre_ok) begin
            first <= 1'b0;
            pcnt  <= first ? PSW'(1) : '0;
          end else begin
            pcnt  <= pcnt + 1'b1;
          end
        end
      end
    end else begin : g_plain
      assign take_v[i] = hit_v[i];
    end
  end

  // =========================================================
  // capture and compare registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      capture_value_o <= '0;
      capture_irq_o   <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (take_v[c]) begin
          capture_value_o[c*BW +: BW] <= base_count_o;
          capture_irq_o[c]            <= 1'b1;
        end else if (capture_ack_i[c]) begin
          capture_irq_o[c]            <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      match_o       <= '0;
      compare_irq_o <= '0;
      compare_out_o <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        match_o[c] <= raw_match[c];
        if (raw_match[c]) begin
          compare_irq_o[c] <= 1'b1;
          compare_out_o[c] <= ~compare_out_o[c];
        end else if (compare_ack_i[c]) begin
          compare_irq_o[c] <= 1'b0;
        end
      end
    end
  end

  // =========================================================
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_capture_stamp: assert property (
    take_v[0] |=> capture_value_o[BW-1:0] == $past(base_count_o) && capture_irq_o[0])
    else $error("capture did not latch the base count");
  a_irq_held: assert property (
    capture_irq_o[1] && !capture_ack_i[1] && !$past(take_v[1]) |=> capture_irq_o[1])
    else $error("capture request dropped without acknowledge");
  a_rise_only: assert property (
    edge_select_i[1:0] == 2'h1 && hit_v[0] |-> flt_v[0] && !lvl_v[0])
    else $error("rising-only channel triggered on a falling edge");
  a_count_free: assert property (
    bt_tick && !rst_pend[RPW-1] |=> base_count_o == $past(base_count_o) + 1'b1)
    else $error("base timer did not advance on its tick");
  a_base_reset: assert property (
    (raw_match[0] && reset_on_match0_i && base_clock_select_i == 2'h0)
      ##1 (base_timer_run_i && base_clock_select_i == 2'h0) |=> base_count_o == '0)
    else $error("base timer not zero two cycles after match 0");
  a_gate_block: assert property (
    gate_v[0] |-> !take_v[6])
    else $error("gated channel accepted a trigger");
  a_gate_arm: assert property (
    take_v[7] && trigger_gate_enable_i[1] |=> gate_v[1])
    else $error("gate did not close after the accepted trigger");
  a_plain_chan: assert property (
    hit_v[0] |-> take_v[0])
    else $error("ungated channel dropped a trigger");
  a_cmp_match: assert property (
    raw_match[2] |=> match_o[2] && compare_irq_o[2] && (compare_out_o[2] != $past(compare_out_o[2])))
    else $error("compare match not signalled");

  c_capture7: cover property (take_v[7] ##1 capture_irq_o[7]);
  c_gate_reopen: cover property (gate_v[0] ##1 !gate_v[0]);
  c_base_reset: cover property (raw_match[0] && reset_on_match0_i ##[1:64] base_count_o == '0);
  c_match_irq: cover property (raw_match[3] ##1 compare_irq_o[3]);

endmodule : cct_top
`default_nettype wire

// [sim/cct_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module cct_partner #(
  parameter int unsigned ACK_DLY = 3
) (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // requests and acknowledges
  input  wire logic [7:0] capture_irq_i,
  input  wire logic [7:0] compare_irq_i,
  output logic      [7:0] capture_ack_o,
  output logic      [7:0] compare_ack_o
);
  logic [ACK_DLY*8-1:0] cap_hist;
  logic [ACK_DLY*8-1:0] cmp_hist;

  // ==========================================================
  // interrupt controller: acks late so a request must stand
  always_ff @(negedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_hist      <= '0;
      cmp_hist      <= '0;
      capture_ack_o <= 8'h00;
      compare_ack_o <= 8'h00;
    end else begin
      cap_hist      <= {cap_hist[ACK_DLY*8-9:0], capture_irq_i};
      cmp_hist      <= {cmp_hist[ACK_DLY*8-9:0], compare_irq_i};
      capture_ack_o <= capture_irq_i & cap_hist[ACK_DLY*8-1 -: 8];
      compare_ack_o <= compare_irq_i & cmp_hist[ACK_DLY*8-1 -: 8];
    end
  end
endmodule : cct_partner
`default_nettype wire

// [sim/test_capture_compare_timer.sv]
`include "cct_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module test_capture_compare_timer;
  logic                   core_clk_i;
  logic                   rst_n_i;
  logic                   run;
  logic [1:0]             clk_sel;
  logic                   rst_m0;
  logic                   in_sel;
  logic [7:0]             deb_set;
  logic [7:0]             pins;
  logic [15:0]            edge_sel;
  logic [15:0]            filt_sel;
  logic [1:0]             gate_en;
  logic [1:0]             gate_clr;
  logic [1:0]             pre_en;
  logic [15:0]            pre_set;
  logic [7:0]             cap_ack;
  logic [127:0]           cap_val;
  logic [7:0]             cap_irq;
  logic [127:0]           cmp_val;
  logic [7:0]             cmp_ack;
  logic [7:0]             match;
  logic [7:0]             cmp_irq;
  logic [7:0]             cmp_out;
  logic [15:0]            count;
  int                     failures;
  int                     cmp_count;

  cct_top cct_top_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .base_timer_run_i(run),
    .base_clock_select_i(clk_sel), .reset_on_match0_i(rst_m0), .input_select_i(in_sel),
    .debounce_setting_i(deb_set), .trigger_input_pin_i(pins), .edge_select_i(edge_sel),
    .filter_select_i(filt_sel), .trigger_gate_enable_i(gate_en), .gate_clear_i(gate_clr),
    .trigger_prescale_enable_i(pre_en), .prescale_setting_i(pre_set),
    .capture_ack_i(cap_ack), .capture_value_o(cap_val), .capture_irq_o(cap_irq),
    .compare_value_i(cmp_val), .compare_ack_i(cmp_ack), .match_o(match),
    .compare_irq_o(cmp_irq), .compare_out_o(cmp_out), .base_count_o(count));

  cct_partner cct_partner_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .capture_irq_i(cap_irq), .compare_irq_i(cmp_irq), .capture_ack_o(cap_ack),
    .compare_ack_o(cmp_ack));

  // ==========================================================
  // helpers
  always #2.5 core_clk_i = ~core_clk_i;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask : chk1

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc

  task automatic wait_cap(input int ch, input int n, output int at);
    at = -1;
    for (int i = 1; i <= n && at < 0; i++) begin
      cyc(1);
      if (cap_irq[ch] === 1'b1) at = i;
    end
  endtask : wait_cap

  // drive one level change and see whether it captured
  task automatic ev(input int ch, input logic lvl, input logic exp);
    int at;
    pins[ch] = lvl;
    wait_cap(ch, 6, at);
    chk1(at >= 0, exp);
    cyc(8);
  endtask : ev

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // scenarios
  task automatic t_edges;
    logic [15:0] rec;
    for (logic [2:0] m = 3'h0; m < 3'h4; m++) begin
      edge_sel[1:0] = m[1:0];
      ev(0, 1'b1, m[0]);
      ev(0, 1'b0, m[1]);
    end
    edge_sel[1:0] = 2'h1;
    pins[0] = 1'b1;
    cyc(1);
    rec = count;
    cyc(1);
    chk(cap_val[15:0], rec);
    chk1(cap_irq[0], 1'b1);
    cyc(1);
    chk1(cap_irq[0], 1'b1);
    chk(cap_val[15:0], rec);
    pins[0] = 1'b0;
    cyc(8);
  endtask : t_edges

  task automatic t_filter;
    int at;
    edge_sel[3:2] = 2'h1;
    filt_sel[3:2] = 2'h2;
    pins[1] = 1'b1;
    cyc(2);
    pins[1] = 1'b0;
    wait_cap(1, 10, at);
    chk1(at >= 0, 1'b0);
    pins[1] = 1'b1;
    wait_cap(1, 10, at);
    chk1(at > 2, 1'b1);
    pins[1] = 1'b0;
    cyc(12);
  endtask : t_filter

  // slower base ticks, then the filter sampling on the base tick
  task automatic t_clock;
    logic [15:0] rec;
    int          at;
    for (int s = 1; s < 4; s++) begin
      clk_sel = 2'(s);
      rec = count;
      cyc(32);
      chk(count, rec + (16'h0020 >> (2 * s - 1)));
    end
    clk_sel = 2'h2;
    filt_sel[3:2] = 2'h3;
    pins[1] = 1'b1;
    wait_cap(1, 40, at);
    chk1(at > 16, 1'b1);
    pins[1] = 1'b0;
    cyc(40);
    clk_sel = 2'h0;
  endtask : t_clock

  task automatic t_gate;
    edge_sel[13:12] = 2'h3;
    gate_en[0] = 1'b1;
    ev(6, 1'b1, 1'b1);
    ev(6, 1'b0, 1'b0);
    gate_clr[0] = 1'b1;
    cyc(1);
    gate_clr[0] = 1'b0;
    ev(6, 1'b1, 1'b1);
    ev(6, 1'b0, 1'b0);
    cmp_val[111:96] = count + 16'h0010;
    cyc(20);
    ev(6, 1'b1, 1'b1);
    cmp_val[111:96] = 16'hFFFF;
    gate_en[0] = 1'b0;
    edge_sel[15:14] = 2'h1;
    gate_en[1] = 1'b1;
    ev(7, 1'b1, 1'b1);
    ev(7, 1'b0, 1'b0);
    ev(7, 1'b1, 1'b0);
    ev(7, 1'b0, 1'b0);
    gate_clr[1] = 1'b1;
    cyc(1);
    gate_clr[1] = 1'b0;
    ev(7, 1'b1, 1'b1);
    ev(7, 1'b0, 1'b0);
    gate_en[1] = 1'b0;
  endtask : t_gate

  task automatic t_prescale;
    logic [6:0] pat;
    pat = 7'h25;
    edge_sel[15:14] = 2'h1;
    pre_set[15:8] = 8'h02;
    pre_en[1] = 1'b1;
    for (int i = 0; i < 7; i++) begin
      ev(7, 1'b1, pat[i]);
      ev(7, 1'b0, 1'b0);
    end
    pre_en[1] = 1'b0;
  endtask : t_prescale

  task automatic t_debounce;
    int at;
    in_sel = 1'b1;
    deb_set = 8'h01;
    pins[7] = 1'b1;
    cyc(3);
    pins[7] = 1'b0;
    wait_cap(7, 40, at);
    chk1(at >= 0, 1'b0);
    pins[7] = 1'b1;
    wait_cap(7, 60, at);
    chk1(at > 8, 1'b1);
    pins[7] = 1'b0;
    cyc(40);
    in_sel = 1'b0;
  endtask : t_debounce

  task automatic t_compare;
    logic [15:0] m;
    logic        o;
    int          at;
    m = count + 16'h0020;
    o = cmp_out[2];
    cmp_val[47:32] = m;
    at = -1;
    for (int i = 0; i < 50 && at < 0; i++) begin
      cyc(1);
      if (match[2] === 1'b1) at = i;
    end
    chk(count, m + 16'h0001);
    chk1(cmp_irq[2], 1'b1);
    chk1(cmp_out[2], ~o);
    cyc(1);
    chk1(match[2], 1'b0);
  endtask : t_compare

  task automatic t_reset_match;
    logic [15:0] m;
    int          at;
    m = count + 16'h0030;
    cmp_val[15:0] = m;
    rst_m0 = 1'b1;
    at = -1;
    for (int i = 0; i < 80 && at < 0; i++) begin
      cyc(1);
      if (match[0] === 1'b1) at = i;
    end
    chk(count, m + 16'h0001);
    cyc(1);
    chk(count, 16'h0000);
    cyc(1);
    chk(count, 16'h0001);
    rst_m0 = 1'b0;
    cmp_val[15:0] = 16'hFFFF;
  endtask : t_reset_match

  task automatic t_run;
    logic [15:0] rec;
    run = 1'b0;
    cyc(1);
    rec = count;
    cyc(5);
    chk(count, rec);
    run = 1'b1;
    cyc(1);
    chk(count, rec + 16'h0001);
  endtask : t_run

  // ==========================================================
  // main sequence and watchdog
  initial begin
    core_clk_i = 1'b0;
    rst_n_i = 1'b0;
    run = 1'b1;
    clk_sel = 2'h0;
    rst_m0 = 1'b0;
    in_sel = 1'b0;
    deb_set = 8'h00;
    pins = 8'h00;
    edge_sel = 16'h0000;
    filt_sel = 16'h0000;
    gate_en = 2'h0;
    gate_clr = 2'h0;
    pre_en = 2'h0;
    pre_set = 16'h0000;
    cmp_val = {8{16'hFFFF}};
    failures = 0;
    cmp_count = 0;
    cyc(2);
    chk(count, 16'h0000);
    rst_n_i = 1'b1;
    cyc(1);
    t_run();
    t_edges();
    t_filter();
    t_clock();
    t_gate();
    t_prescale();
    t_debounce();
    t_compare();
    t_reset_match();
    print_verdict();
  end

  initial begin
    #50000;
    failures++;
    print_verdict();
  end
endmodule : test_capture_compare_timer
`default_nettype wire
